// ---- src/clo_gate.sv ----
`timescale 1ns/1ps
// One output's gating: on bit, chosen source, optional external PWM
module clo_gate (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic on_bit,
  input wire logic use_audio,
  input wire logic audio_level,
  input wire logic pattern_level,
  input wire logic ext_gate_en,
  input wire logic ext_pwm,
  output logic drive
);
  logic src; // Level of the selected internal source
  logic next_drive;
  always_comb begin
    src = use_audio ? audio_level : pattern_level;
    next_drive = on_bit & src;
    if (ext_gate_en) begin
      next_drive = next_drive & ext_pwm;
    end
  end
  // Registered so pin level is glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= 1'b0;
    end else begin
      drive <= next_drive;
    end
  end
endmodule

// ---- src/clo_pkg.sv ----
package clo_pkg;
  // Register word indices; the byte address is four times the index
  localparam logic [7:0] idx_color_output_control = 8'h00;
  localparam logic [7:0] idx_external_pwm_routing = 8'h07;
  localparam logic [7:0] idx_block_enables = 8'h08;
  localparam logic [7:0] idx_flash_control = 8'h10;
  localparam logic [7:0] idx_set_one_current_scale = 8'h12;
  localparam logic [7:0] idx_set_two_current_scale = 8'h13;
  localparam logic [7:0] idx_display_config = 8'h20;
  localparam int addr_width = 10;
  // Field positions
  localparam int pos_set_one_switch_mode = 7;
  localparam int pos_set_two_switch_mode = 6;
  localparam int pos_white_low_gate = 7;
  localparam int pos_white_high_gate = 6;
  localparam int pos_flash_ext_gate = 5;
  localparam int pos_sel_lo = 0;
  localparam int pos_display_flag = 0;
  // Reset values
  localparam logic [7:0] rst_reg = 8'h00;
  localparam logic [5:0] color_mask = 6'h3F;
  // Source selector codes
  typedef enum logic [1:0] {
    clo_sel_pattern_both = 2'b00,
    clo_sel_audio_one = 2'b01,
    clo_sel_audio_two = 2'b10,
    clo_sel_audio_both = 2'b11
  } clo_sel_type;
  // Per-output drive info toward the analog drivers
  typedef struct packed {
    logic [5:0] on;
    logic [1:0] switch_mode;
    logic [11:0] current_code;
  } clo_drive_type;
endpackage

// ---- src/clo_top.sv ----
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
// Operation
// - selector routes audio and pattern to sets
// - on bit must be set for activity
// - bits 5..0 turn color outputs on
// - bits 7,6 pick switch or sink mode
// - external PWM routing bits per output
// - flash bit lets PWM gate flash
// - display flag: low group gates all whites
// - internal and external PWM are ANDed
// - 2-bit code scales output max current
// - current scale registers reset to zero
module clo_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [5:0] audio_level,
  input wire logic [5:0] pattern_level,
  input wire logic ext_pwm,
  input wire logic flash_level,
  input wire logic [5:0] white_level,
  output logic [5:0] color_drive,
  output logic flash_drive,
  output logic [5:0] white_drive,
  output clo_pkg::clo_drive_type drive_info
);
  // ****************************************
  // Sizes
  // ****************************************
  // Six color outputs, two sets of three; bit 5 is red of set one
  localparam int num_colors = 6;
  // Outputs per set; the upper half of the vector is set one
  localparam int set_size = 3;
  // Width of one maximum-current code
  localparam int code_width = 2;
  // Codes of one set packed red, green, blue from the top
  localparam int scale_width = set_size * code_width;
  // Registers are one byte wide on a 32-bit bus
  localparam int reg_width = 8;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] color_output_control; // Modes and on bits
  logic [7:0] external_pwm_routing; // PWM gate bits
  logic [7:0] block_enables; // Source selector in low bits
  logic [7:0] flash_control; // Flash gate bit
  logic [5:0] set_one_current_scale; // Set one codes
  logic [5:0] set_two_current_scale; // Set two codes
  logic display_config_flag; // White grouping flag
  // Bus data-phase capture
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] rd_byte;
  logic [7:0] next_rd;
  logic [7:0] addr_idx;
  logic word_ok;
  logic accept;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Always zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Word index; byte lanes below bit 2 only matter for alignment
  assign addr_idx = haddr[clo_pkg::addr_width - 1:2];
  // Unaligned writes are dropped rather than guessed at
  assign word_ok = (haddr[1:0] == 2'b00);
  // A transfer is taken only when the bus as a whole is ready
  assign accept = hsel & htrans[1] & hready;

  // ****************************************
  // Write strobes
  // ****************************************
  // One strobe per register, decoded from the captured index
  // Decoding once here keeps each register's process small
  logic wr_color; // Color control write this cycle
  logic wr_routing; // PWM routing write this cycle
  logic wr_enables; // Enables write this cycle
  logic wr_flash; // Flash control write this cycle
  logic wr_scale_one; // Set one scale write this cycle
  logic wr_scale_two; // Set two scale write this cycle
  logic wr_display; // Display flag write this cycle
  assign wr_color = wr_pend &
    (wr_idx == clo_pkg::idx_color_output_control);
  assign wr_routing = wr_pend &
    (wr_idx == clo_pkg::idx_external_pwm_routing);
  assign wr_enables = wr_pend &
    (wr_idx == clo_pkg::idx_block_enables);
  assign wr_flash = wr_pend &
    (wr_idx == clo_pkg::idx_flash_control);
  assign wr_scale_one = wr_pend &
    (wr_idx == clo_pkg::idx_set_one_current_scale);
  assign wr_scale_two = wr_pend &
    (wr_idx == clo_pkg::idx_set_two_current_scale);
  assign wr_display = wr_pend &
    (wr_idx == clo_pkg::idx_display_config);

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= clo_pkg::rst_reg;
    end else begin
      wr_pend <= accept & hwrite & word_ok;
      wr_idx <= addr_idx;
    end
  end

  // Read mux; unmapped reads give zero
  // Sampled at the address phase so data stands through the data phase
  always_comb begin
    case (addr_idx)
      clo_pkg::idx_color_output_control: begin
        next_rd = color_output_control;
      end
      clo_pkg::idx_external_pwm_routing: begin
        next_rd = external_pwm_routing;
      end
      clo_pkg::idx_block_enables: begin
        next_rd = block_enables;
      end
      clo_pkg::idx_flash_control: begin
        next_rd = flash_control;
      end
      clo_pkg::idx_set_one_current_scale: begin
        next_rd = {2'h0, set_one_current_scale};
      end
      clo_pkg::idx_set_two_current_scale: begin
        next_rd = {2'h0, set_two_current_scale};
      end
      clo_pkg::idx_display_config: begin
        next_rd = {7'h00, display_config_flag};
      end
      default: begin
        next_rd = 8'h00;
      end
    endcase
  end

  // Read data registered into data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte <= clo_pkg::rst_reg;
    end else if (accept & ~hwrite) begin
      rd_byte <= next_rd;
    end
  end
  assign hrdata = {24'h000000, rd_byte};

  // ****************************************
  // Register writes
  // ****************************************
  // Each register is written in the data phase, while hwdata stands
  // Color control: modes in bits 7:6, on bits in 5:0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      color_output_control <= clo_pkg::rst_reg;
    end else if (wr_color) begin
      color_output_control <= hwdata[7:0];
    end
  end

  // PWM routing: one gate bit per output or white group
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      external_pwm_routing <= clo_pkg::rst_reg;
    end else if (wr_routing) begin
      external_pwm_routing <= hwdata[7:0];
    end
  end

  // Enables: only the selector bits are used here
  // The other bits are kept so software reads back what it wrote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_enables <= clo_pkg::rst_reg;
    end else if (wr_enables) begin
      block_enables <= hwdata[7:0];
    end
  end

  // Flash control: only the gate bit matters to this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_control <= clo_pkg::rst_reg;
    end else if (wr_flash) begin
      flash_control <= hwdata[7:0];
    end
  end

  // Set one scale codes; reserved top bits are never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_one_current_scale <= clo_pkg::rst_reg[5:0];
    end else if (wr_scale_one) begin
      set_one_current_scale <= hwdata[5:0];
    end
  end

  // Set two scale codes; same packing as set one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_two_current_scale <= clo_pkg::rst_reg[5:0];
    end else if (wr_scale_two) begin
      set_two_current_scale <= hwdata[5:0];
    end
  end

  // Display flag, a single bit in a register of its own
  // Kept apart so a routing write cannot disturb the white grouping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_config_flag <= 1'b0;
    end else if (wr_display) begin
      display_config_flag <= hwdata[clo_pkg::pos_display_flag];
    end
  end

  // ****************************************
  // Source routing
  // ****************************************
  clo_pkg::clo_sel_type sel;
  logic set_one_audio;
  logic set_two_audio;
  assign sel = clo_pkg::clo_sel_type'(block_enables[clo_pkg::pos_sel_lo +: 2]);
  // Which sets follow audio; a set not on audio follows the pattern generator
  // A selector change takes effect on the next registered output edge
  // so no output sees a half-switched source
  always_comb begin
    case (sel)
      clo_pkg::clo_sel_pattern_both: begin
        set_one_audio = 1'b0;
        set_two_audio = 1'b0;
      end
      clo_pkg::clo_sel_audio_one: begin
        set_one_audio = 1'b1;
        set_two_audio = 1'b0;
      end
      clo_pkg::clo_sel_audio_two: begin
        set_one_audio = 1'b0;
        set_two_audio = 1'b1;
      end
      clo_pkg::clo_sel_audio_both: begin
        set_one_audio = 1'b1;
        set_two_audio = 1'b1;
      end
      default: begin
        set_one_audio = 1'b0;
        set_two_audio = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Color outputs
  // ****************************************
  // Bit 5 is red of set one down to bit 0 blue of set two
  // Every output has its own gate, so a routing bit affects one pin
  // The dimming input is shared; its rate is the far side's concern
  // Outputs are registered, which costs one cycle of latency
  genvar gi;
  generate
    for (gi = 0; gi < num_colors; gi++) begin : g_color
      clo_gate u_gate (
        .hclk(hclk),
        .hresetn(hresetn),
        .on_bit(color_output_control[gi]),
        .use_audio(gi >= set_size ? set_one_audio : set_two_audio),
        .audio_level(audio_level[gi]),
        .pattern_level(pattern_level[gi]),
        .ext_gate_en(external_pwm_routing[gi]),
        .ext_pwm(ext_pwm),
        .drive(color_drive[gi])
      );
    end
  endgenerate

  // ****************************************
  // Flash and white gating
  // ****************************************
  logic next_flash;
  logic [5:0] white_gate;
  logic [5:0] next_white;
  always_comb begin
    // Flash passes its level unless routed to the dimming input
    next_flash = flash_level;
    if (flash_control[clo_pkg::pos_flash_ext_gate]) begin
      next_flash = flash_level & ext_pwm;
    end
    // Whites 1-4 always follow the low group routing bit
    white_gate[3:0] = {4{external_pwm_routing[
      clo_pkg::pos_white_low_gate]}};
    // Display flag hands whites 5-6 to the low group bit
    if (display_config_flag) begin
      white_gate[5:4] = {2{external_pwm_routing[
        clo_pkg::pos_white_low_gate]}};
    end else begin
      white_gate[5:4] = {2{external_pwm_routing[
        clo_pkg::pos_white_high_gate]}};
    end
    // A gated white is lit only while the dimming input is high
    next_white = white_level & ~(white_gate & {6{~ext_pwm}});
  end

  // Registered for clean pin levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_drive <= 1'b0;
      white_drive <= 6'h00;
    end else begin
      flash_drive <= next_flash;
      white_drive <= next_white;
    end
  end

  // ****************************************
  // Driver configuration
  // ****************************************
  // Codes 0..3 mean a quarter up to full scale in the analog driver
  // Left combinational: the analog side settles far slower than a clock
  // Mode bits only choose sink or switch; on bits still gate the pins
  always_comb begin
    drive_info.on = color_output_control[5:0] & clo_pkg::color_mask;
    drive_info.switch_mode = {
      color_output_control[clo_pkg::pos_set_one_switch_mode],
      color_output_control[clo_pkg::pos_set_two_switch_mode]};
    drive_info.current_code = {set_one_current_scale,
                               set_two_current_scale};
  end
endmodule

// ---- verif/clo_properties.sv ----
`timescale 1ns/1ps
// ****
// Port checker
// ****
module clo_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [5:0] audio_level,
  input wire logic [5:0] pattern_level,
  input wire logic flash_level,
  input wire logic [5:0] white_level,
  input wire logic [5:0] color_drive,
  input wire logic flash_drive,
  input wire logic [5:0] white_drive,
  input wire clo_pkg::clo_drive_type drive_info
);
  logic acc; // Transfer taken at this edge
  assign acc = hsel && htrans[1] && hready;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus wait or error seen");
  a_scale_reset: assert property ($rose(hresetn) |->
    drive_info.current_code == 12'h000) else $error("scale not cleared");
  a_ctl_write: assert property (acc && hwrite && haddr == 32'h0 |=>
    ##1 {drive_info.switch_mode, drive_info.on} == $past(hwdata[7:0]))
    else $error("control write lost");
  a_scale_write: assert property (acc && hwrite && haddr == 32'h48 |=>
    ##1 drive_info.current_code[11:6] == $past(hwdata[5:0]))
    else $error("scale write lost");
  a_scale_read: assert property (acc && !hwrite && haddr == 32'h48 |=>
    hrdata[7:0] == {2'b00, drive_info.current_code[11:6]})
    else $error("scale read wrong");
  a_on_gates: assert property (
    (color_drive & ~$past(drive_info.on)) == 6'h00)
    else $error("output lit while off");
  a_src_only: assert property (
    (color_drive & ~$past(audio_level | pattern_level)) == 6'h00)
    else $error("output lit with no source");
  a_flash_pass: assert property (flash_drive |-> $past(flash_level))
    else $error("flash lit with no level");
  a_white_pass: assert property (
    (white_drive & ~$past(white_level)) == 6'h00)
    else $error("white lit with no level");
endmodule
bind clo_top clo_properties clo_properties_inst (.*);

// ---- verif/clo_pwm_src.sv ----
`timescale 1ns/1ps
// ****
// External dimming source
// ****
module clo_pwm_src #(
  parameter int half_cycles = 12500 // 2 x 12500 x 40 ns: 1 kHz, the top rate
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic pwm
);
  int cnt; // Cycles in current half period
  // Free running square wave, never faster than the ceiling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      pwm <= 1'b0;
    end else if (cnt == half_cycles - 1) begin
      cnt <= 0;
      pwm <= ~pwm;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
// ****
// Bench with register model
// ****
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, ext_pwm, flash_drive, p;
  logic [5:0] au = 6'h00, pa = 6'h00, wl = 6'h00;
  logic fl = 1'b0;
  logic [5:0] color_drive, white_drive;
  clo_pkg::clo_drive_type drive_info;
  logic [7:0] rm [64]; // Model, by word index
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 64457;
  int k;
  // Last entry unmapped on purpose
  localparam logic [7:0] adr [8] = '{8'h00, 8'h1C, 8'h20, 8'h40, 8'h48,
    8'h4C, 8'h80, 8'h0C};
  // Only bits with a defined meaning are compared
  localparam logic [31:0] cm [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFFFF03, 32'hFFFFFF20, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFF01,
    32'hFFFFFFFF};
  clo_top clo_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .audio_level(au),
    .pattern_level(pa), .ext_pwm(ext_pwm), .flash_level(fl),
    .white_level(wl), .color_drive(color_drive), .flash_drive(flash_drive),
    .white_drive(white_drive), .drive_info(drive_info));
  clo_pwm_src clo_pwm_src_inst (.hclk(hclk), .hresetn(hresetn),
    .pwm(ext_pwm));
  always #20 hclk = ~hclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One edge with hready high, bounded
  task wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        error_cnt++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt;
    htrans <= 2'b00;
    hwdata <= d;
    wt;
    r = hrdata;
  endtask
  task wr(input int i, input logic [31:0] d);
    xfer(1'b1, adr[i], d);
    if (i < 7)
      rm[adr[i][7:2]] = (i == 4 || i == 5) ? d[7:0] & 8'h3F : d[7:0];
  endtask
  task rd(input int i);
    xfer(1'b0, adr[i], 32'h0);
    chk(r & cm[i], {24'h0, rm[adr[i][7:2]]} & cm[i]);
  endtask
  // Random levels, then outputs against the model
  task oc;
    logic [5:0] s, g;
    {au, pa, wl, fl} <= 19'($random(seed));
    @(posedge hclk);
    p = ext_pwm;
    @(posedge hclk);
    s = {rm[8][0] ? au[5:3] : pa[5:3], rm[8][1] ? au[2:0] : pa[2:0]};
    g = rm[7][5:0] & {6{~p}};
    chk(color_drive, rm[0][5:0] & s & ~g);
    g = {{2{rm[32][0] ? rm[7][7] : rm[7][6]}}, {4{rm[7][7]}}} & {6{~p}};
    chk(white_drive, wl & ~g);
    chk(flash_drive, fl & ~(rm[16][5] & ~p));
    chk(drive_info, {rm[0][5:0], rm[0][7:6], rm[18][5:0], rm[19][5:0]});
  endtask
  initial begin
    foreach (rm[j])
      rm[j] = 8'h00;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(4);
    rd(5);
    xfer(1'b1, 8'h21, 32'hFF);
    rd(2);
    // Long enough for the dimming input to show both levels
    repeat (3000) begin
      k = {$random(seed)} % 8;
      wr(k, $random(seed));
      k = {$random(seed)} % 8;
      rd(k);
      oc;
    end
    close_out;
  end
endmodule
